// ===== core/umd_defs.svh
// Behaviour
// - Receiver takes 16 samples per bit normally, 8 in double speed.
// - First voting sample is number 8 normally, number 4 in double speed.
// - Middle voting sample is number 9 normally, number 5 in double speed.
// - Frames of 5 to 9 data bits are received.
// - Sender and receiver baud errors should each stay within half the tolerance.
// - Normal speed tolerates more mismatch; about 1.5 vs 1.0 percent at ten bits.
// - With address filtering on, non-address frames are dropped before the buffer.
// - Address filtering never affects the transmitter.
// - Frame type is first stop bit for 5-8 bits, ninth bit for 9 bits.
// - Frame type one means address frame, zero means data frame.
// - An accepted address frame sets receive complete like any other frame.
// - Filter bit shares the status register with write-one-to-clear transmit complete.
// - One data address: writes fill transmit buffer, reads return receive buffer.
// - Unused upper bits ignored on transmit and read as zero on receive.
// - Data writes while the transmit buffer is full are ignored.
// - Buffered data moves to the empty shift register and is shifted out.
// - Receive buffer is a two-entry first-in first-out queue.
// - A read of the data location advances the receive queue only when it holds a frame and the receiver is enabled.
// - Each bit is the majority of three centre samples.
// - Double speed cuts the samples per bit from 16 to 8.
`ifndef UMD_DEFS_SVH
`define UMD_DEFS_SVH
`define UMD_OFF_DATA 12'h000
`define UMD_OFF_CSA  12'h004
`define UMD_OFF_CTRL 12'h008
`define UMD_OFF_BAUD 12'h00c
`define UMD_SPB_N    5'h10
`define UMD_SPB_D    5'h08
`define UMD_SF_N     5'h08
`define UMD_SF_D     5'h04
`define UMD_SM_N     5'h09
`define UMD_SM_D     5'h05
`define UMD_VOTE_GAP 5'h02
`define UMD_CSZ_9    3'h7
`define UMD_CSZ_RST  3'h3
`define UMD_BAUD_RST 12'h000
`define UMD_TXC_BIT  6
`define UMD_DBL_BIT  1
`define UMD_FILT_BIT 0
`define UMD_RXEN_BIT 0
`define UMD_TXEN_BIT 1
`define UMD_TX8_BIT  2
`define UMD_STOP_BIT 7
`define UMD_CSZ_MSB  6
`define UMD_CSZ_LSB  4
`define UMD_BAUD_MSB 11
`endif

// ===== core/umd_pkg.sv
package umd_pkg;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} umd_rx_e;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} umd_tx_e;
    typedef struct packed {
        logic             rx_s1;
        logic             rx_s2;
        logic             pready;
        logic             perr;
        logic [31:0]      prdata;
        logic             txc;
        logic             filt;
        logic             dbl;
        logic             rx_en;
        logic             tx_en;
        logic             tx8;
        logic [2:0]       csz;
        logic             stop2;
        logic [11:0]      baud;
        logic [11:0]      div;
        umd_rx_e          rx_st;
        logic [4:0]       rx_cnt;
        logic [3:0]       rx_bit;
        logic [1:0]       rx_v;
        logic [8:0]       rx_sh;
        logic             dor;
        logic [1:0][9:0]  fifo;
        logic             rd;
        logic [1:0]       cnt;
        logic [8:0]       tb;
        logic             tb_full;
        umd_tx_e          tx_st;
        logic [4:0]       tx_cnt;
        logic [3:0]       tx_bit;
        logic [8:0]       tx_sh;
        logic             txd;
    } umd_state_s;
endpackage

// ===== core/umd_uart.sv
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "umd_defs.svh"
module umd_uart (
    input  wire logic        pclk,           // System clock, 100 MHz.
    input  wire logic        presetn,        // Asynchronous reset, active low.
    input  wire logic        psel,           // APB select.
    input  wire logic        penable,        // APB access phase.
    input  wire logic        pwrite,         // APB direction, high for write.
    input  wire logic [11:0] paddr,          // APB byte address.
    input  wire logic [31:0] pwdata,         // APB write data.
    output logic [31:0]      prdata,         // APB read data.
    output logic             pready,         // APB ready.
    output logic             pslverr,        // APB error on unmapped address.
    input  wire logic        serial_in_pin,  // Serial receive line.
    output logic             serial_out_pin  // Serial transmit line.
);
    import umd_pkg::*;

    umd_state_s s;
    umd_state_s n;
    logic       tick;
    logic [4:0] spb;
    logic [4:0] sf;
    logic [4:0] sm;
    logic [4:0] smp;
    logic [3:0] nb;
    logic       vb;
    logic       vote;
    logic       acc;
    logic       hit;
    logic       wr_data;
    logic       pop;
    logic       push;
    logic       frame_done;
    logic       ftype;
    logic       tx_done;
    logic [31:0] rdat;

    // Data bits per character; codes 4 to 6 fall back to their low bits.
    function automatic logic [3:0] nbits(input logic [2:0] c);
        nbits = (c == `UMD_CSZ_9) ? 4'h9 : {2'h0, c[1:0]} + 4'h5;
    endfunction

    // Two or three high samples give one.
    function automatic logic maj(input logic [2:0] v);
        maj = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    // Keeps only the bits that belong to the character.
    function automatic logic [8:0] dmask(input logic [2:0] c, input logic [8:0] d);
        dmask = d & ~(9'h1ff << nbits(c));
    endfunction

    // One process computes the whole next state from the current one.
    always_comb
    begin
        n = s;
        smp = 5'h00;
        vote = 1'b0;
        frame_done = 1'b0;
        tx_done = 1'b0;
        push = 1'b0;
        rdat = 32'h0000_0000;
        tick = (s.div == s.baud);
        spb = s.dbl ? `UMD_SPB_D : `UMD_SPB_N;
        sf = s.dbl ? `UMD_SF_D : `UMD_SF_N;
        sm = s.dbl ? `UMD_SM_D : `UMD_SM_N;
        nb = nbits(s.csz);
        vb = maj({s.rx_s2, s.rx_v[1], s.rx_v[0]});
        ftype = (s.csz == `UMD_CSZ_9) ? s.rx_sh[8] : vb;
        acc = psel & penable & s.pready;
        hit = (paddr == `UMD_OFF_DATA) | (paddr == `UMD_OFF_CSA) |
              (paddr == `UMD_OFF_CTRL) | (paddr == `UMD_OFF_BAUD);
        wr_data = acc & pwrite & (paddr == `UMD_OFF_DATA);
        pop = acc & ~pwrite & (paddr == `UMD_OFF_DATA) & s.rx_en & (s.cnt != 2'h0);

        // The line input is only read after two flops.
        n.rx_s1 = serial_in_pin;
        n.rx_s2 = s.rx_s1;
        n.div = tick ? 12'h000 : s.div + 12'h001;

        // Read mux; status bits show the head of the receive queue.
        case (paddr)
            `UMD_OFF_DATA: rdat = {24'h00_0000, s.fifo[s.rd][7:0]};
            `UMD_OFF_CSA:  rdat = {24'h00_0000, s.cnt != 2'h0, s.txc, ~s.tb_full,
                                   s.fifo[s.rd][9] & (s.cnt != 2'h0), s.dor, 1'b0, s.dbl, s.filt};
            `UMD_OFF_CTRL: rdat = {24'h00_0000, s.stop2, s.csz, s.fifo[s.rd][8], s.tx8, s.tx_en, s.rx_en};
            `UMD_OFF_BAUD: rdat = {20'h0_0000, s.baud};
            default:       rdat = 32'h0000_0000;
        endcase

        // Two-cycle access: ready and data are registered together.
        n.pready = psel & penable & ~s.pready;
        if (psel & penable & ~s.pready)
        begin
            n.prdata = pwrite ? 32'h0000_0000 : rdat;
            n.perr = ~hit;
        end

        // Register writes land only at the completing edge.
        if (acc & pwrite)
        begin
            case (paddr)
                `UMD_OFF_DATA:
                begin
                    if (!s.tb_full)
                    begin
                        n.tb = dmask(s.csz, {s.tx8, pwdata[7:0]});
                        n.tb_full = 1'b1;
                    end
                end
                `UMD_OFF_CSA:
                begin
                    // Filter bit shares the word with transmit complete, so a stray one clears it.
                    if (pwdata[`UMD_TXC_BIT])
                        n.txc = 1'b0;
                    n.dbl = pwdata[`UMD_DBL_BIT];
                    n.filt = pwdata[`UMD_FILT_BIT];
                end
                `UMD_OFF_CTRL:
                begin
                    n.rx_en = pwdata[`UMD_RXEN_BIT];
                    n.tx_en = pwdata[`UMD_TXEN_BIT];
                    n.tx8 = pwdata[`UMD_TX8_BIT];
                    n.csz = pwdata[`UMD_CSZ_MSB:`UMD_CSZ_LSB];
                    n.stop2 = pwdata[`UMD_STOP_BIT];
                end
                `UMD_OFF_BAUD: n.baud = pwdata[`UMD_BAUD_MSB:0];
                default: ;
            endcase
        end

        // Receiver: sample counter restarts at one on each bit boundary.
        if (!s.rx_en)
        begin
            n.rx_st = RX_IDLE;
            n.cnt = 2'h0;
            n.dor = 1'b0;
        end
        else if (tick)
        begin
            if (s.rx_st == RX_IDLE)
            begin
                if (!s.rx_s2)
                begin
                    n.rx_st = RX_START;
                    n.rx_cnt = 5'h01;
                    n.rx_bit = 4'h0;
                    n.rx_sh = 9'h000;
                end
            end
            else
            begin
                smp = (s.rx_cnt == spb) ? 5'h01 : s.rx_cnt + 5'h01;
                n.rx_cnt = smp;
                if (smp == 5'h01)
                begin
                    case (s.rx_st)
                        RX_START: n.rx_st = RX_DATA;
                        RX_DATA:
                        begin
                            if (s.rx_bit == nb - 4'h1)
                                n.rx_st = RX_STOP;
                            else
                                n.rx_bit = s.rx_bit + 4'h1;
                        end
                        default: ;
                    endcase
                end
                if (smp == sf)
                    n.rx_v[0] = s.rx_s2;
                if (smp == sm)
                    n.rx_v[1] = s.rx_s2;
                // Voting at the bit centre leaves half the mismatch budget to each end.
                if (smp == sf + `UMD_VOTE_GAP)
                begin
                    vote = 1'b1;
                    case (s.rx_st)
                        RX_START:
                        begin
                            if (vb)
                                n.rx_st = RX_IDLE;
                        end
                        RX_DATA: n.rx_sh[s.rx_bit] = vb;
                        RX_STOP:
                        begin
                            // Leaving at the vote lets the next start bit come early.
                            frame_done = 1'b1;
                            n.rx_st = RX_IDLE;
                        end
                        default: n.rx_st = RX_IDLE;
                    endcase
                end
            end
        end

        // Queue: pop first, so a push into a full queue being read still fits.
        if (pop)
        begin
            n.rd = ~s.rd;
            n.cnt = s.cnt - 2'h1;
        end
        if (frame_done & (~s.filt | ftype))
        begin
            if (n.cnt != 2'h2)
            begin
                push = 1'b1;
                n.fifo[n.rd ^ n.cnt[0]] = {~vb, s.rx_sh};
                n.cnt = n.cnt + 2'h1;
                n.dor = 1'b0;
            end
            else
                n.dor = 1'b1;
        end

        // Transmitter ignores the filter bit entirely.
        if (s.tx_st == TX_IDLE)
        begin
            if (s.tb_full & s.tx_en)
            begin
                n.tx_sh = s.tb;
                n.tb_full = 1'b0;
                n.tx_st = TX_START;
                n.tx_cnt = 5'h00;
                n.tx_bit = 4'h0;
                n.txd = 1'b0;
            end
        end
        else if (tick)
        begin
            if (s.tx_cnt != spb - 5'h01)
                n.tx_cnt = s.tx_cnt + 5'h01;
            else
            begin
                n.tx_cnt = 5'h00;
                case (s.tx_st)
                    TX_START:
                    begin
                        n.tx_st = TX_DATA;
                        n.txd = s.tx_sh[0];
                    end
                    TX_DATA:
                    begin
                        if (s.tx_bit == nb - 4'h1)
                        begin
                            n.tx_st = TX_STOP;
                            n.txd = 1'b1;
                            n.tx_bit = 4'h0;
                        end
                        else
                        begin
                            n.tx_bit = s.tx_bit + 4'h1;
                            n.txd = s.tx_sh[s.tx_bit + 4'h1];
                        end
                    end
                    TX_STOP:
                    begin
                        if (s.stop2 & (s.tx_bit == 4'h0))
                            n.tx_bit = 4'h1;
                        else
                        begin
                            n.tx_st = TX_IDLE;
                            tx_done = 1'b1;
                        end
                    end
                    default: n.tx_st = TX_IDLE;
                endcase
            end
        end
        // Set beats a same-cycle clear so no completion is lost.
        if (tx_done & ~n.tb_full)
            n.txc = 1'b1;
    end

    // All state in one register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
            s.rx_s1 <= 1'b1;
            s.rx_s2 <= 1'b1;
            s.rx_v <= 2'h3;
            s.csz <= `UMD_CSZ_RST;
            s.baud <= `UMD_BAUD_RST;
            s.txd <= 1'b1;
        end
        else
            s <= n;
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.perr;
    assign serial_out_pin = s.txd;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wait;
        psel && penable && !pready;
    endsequence

    // Bus handshake: every access has exactly one wait cycle.
    chk_apb_wait_ready: assert property (s_setup ##1 s_wait |=> pready)
        else $error("APB access not completed after one wait cycle.");

    // Receiver sampling, start validation and voting.
    chk_sample_span: assert property (s.rx_st != RX_IDLE
                                      |-> s.rx_cnt <= (s.dbl ? `UMD_SPB_D : `UMD_SPB_N))
        else $error("Receive sample count exceeds samples per bit.");
    chk_start_reject: assert property (vote && s.rx_st == RX_START && vb |=> s.rx_st == RX_IDLE)
        else $error("High start vote did not reject the start bit.");
    chk_mid_capture: assert property (smp == sm && smp != 5'h00 |=> s.rx_v[1] == $past(s.rx_s2))
        else $error("Middle sample not captured.");

    // Address filter and receive queue.
    chk_filter_drop: assert property (frame_done && s.filt && !ftype && !pop |=> s.cnt == $past(s.cnt))
        else $error("Filtered data frame entered the queue.");
    chk_addr_take: assert property (frame_done && ftype && s.cnt != 2'h2 && !pop
                                   |=> s.cnt == $past(s.cnt) + 2'h1)
        else $error("Address frame not queued.");
    chk_read_pop: assert property (pop && !push |=> s.cnt == $past(s.cnt) - 2'h1)
        else $error("Data read did not advance the queue.");
    chk_dor_set: assert property (frame_done && (!s.filt || ftype) && s.cnt == 2'h2 && !pop |=> s.dor)
        else $error("Frame lost to a full queue without the overrun flag.");
    chk_rx_flush: assert property (!s.rx_en |=> s.cnt == 2'h0)
        else $error("Disabled receiver kept queued frames.");

    // Transmit buffer, shift register and completion flag.
    chk_full_write: assert property (wr_data && s.tb_full |=> s.tb == $past(s.tb))
        else $error("Write to full transmit buffer changed it.");
    chk_tx_load: assert property (s.tx_st == TX_IDLE && s.tb_full && s.tx_en
                                  |=> s.tx_st == TX_START && !serial_out_pin && !s.tb_full)
        else $error("Buffered byte not moved to the shift register.");
    chk_txc_set: assert property (tx_done && !s.tb_full && !wr_data |=> s.txc)
        else $error("Transmit complete not set after the last frame.");
endmodule
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "umd_defs.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rxd;
    logic        txd;
    logic [4:0]  spb;
    logic [3:0]  nbits;
    logic [31:0] rdata;
    logic        last_err;
    int          error_cnt;
    int          check_count;
    int          n;

    umd_uart u_dut (
        .pclk           (pclk),
        .presetn        (presetn),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .paddr          (paddr),
        .pwdata         (pwdata),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .serial_in_pin  (rxd),
        .serial_out_pin (txd)
    );

    umd_node u_node (
        .pclk     (pclk),
        .line_in  (txd),
        .line_out (rxd),
        .spb      (spb),
        .nbits    (nbits)
    );

    // Free running 100 MHz clock.
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic complete_run();
        if (error_cnt == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One APB transfer; an idle edge follows so back-to-back calls never assign psel twice in a step.
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        int k;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (k >= 20)
        begin
            error_cnt++;
            complete_run();
        end
        rdata    = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        `CHK(rdata, exp)
    endtask

    // Main sequence: reset, filtering, queue depth, double speed, short frames, transmit.
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        spb = 5'h10;
        nbits = 4'h9;
        error_cnt = 0;
        check_count = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(`UMD_OFF_CSA, 32'h20);
        rd_chk(`UMD_OFF_CTRL, 32'h30);
        rd_chk(`UMD_OFF_BAUD, 32'h0);
        rd_chk(12'h010, 32'h0);
        `CHK(last_err, 1'b1)
        apb(1'b1, `UMD_OFF_CTRL, 32'h73);
        apb(1'b1, `UMD_OFF_CSA, 32'h01);
        u_node.send_frame(9'h033, 1'b1);
        rd_chk(`UMD_OFF_CSA, 32'h21);
        u_node.send_frame(9'h15a, 1'b1);
        rd_chk(`UMD_OFF_CSA, 32'ha1);
        rd_chk(`UMD_OFF_CTRL, 32'h7b);
        rd_chk(`UMD_OFF_DATA, 32'h5a);
        rd_chk(`UMD_OFF_CSA, 32'h21);
        // The addressed node opens its filter for the data that follows.
        apb(1'b1, `UMD_OFF_CSA, 32'h00);
        u_node.send_frame(9'h011, 1'b1);
        u_node.send_frame(9'h022, 1'b1);
        u_node.send_frame(9'h033, 1'b1);
        rd_chk(`UMD_OFF_CSA, 32'ha8);
        rd_chk(`UMD_OFF_DATA, 32'h11);
        rd_chk(`UMD_OFF_DATA, 32'h22);
        apb(1'b0, `UMD_OFF_CSA, 32'h0);
        `CHK(rdata[7], 1'b0)
        apb(1'b1, `UMD_OFF_CSA, 32'h03);
        spb = 5'h08;
        u_node.send_frame(9'h1c3, 1'b1);
        rd_chk(`UMD_OFF_DATA, 32'hc3);
        spb = 5'h10;
        apb(1'b1, `UMD_OFF_CSA, 32'h01);
        // Five-bit frames: the first stop bit decides the frame type.
        apb(1'b1, `UMD_OFF_CTRL, 32'h03);
        nbits = 4'h5;
        u_node.send_frame(9'h015, 1'b0);
        rd_chk(`UMD_OFF_CSA, 32'h21);
        u_node.send_frame(9'h00a, 1'b1);
        rd_chk(`UMD_OFF_DATA, 32'h0a);
        // Ninth bit is written before the data; the third write meets a full buffer.
        apb(1'b1, `UMD_OFF_CTRL, 32'h77);
        nbits = 4'h9;
        apb(1'b1, `UMD_OFF_DATA, 32'ha5);
        apb(1'b1, `UMD_OFF_DATA, 32'h3c);
        apb(1'b1, `UMD_OFF_DATA, 32'hff);
        n = 0;
        while (u_node.rx_q.size() < 2 && n < 3000)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 3000)
        begin
            error_cnt++;
            complete_run();
        end
        repeat (400) @(posedge pclk);
        `CHK(u_node.rx_q.size(), 2)
        `CHK(u_node.rx_q[0], 9'h1a5)
        `CHK(u_node.rx_q[1], 9'h13c)
        rd_chk(`UMD_OFF_CSA, 32'h61);
        apb(1'b1, `UMD_OFF_CSA, 32'h41);
        rd_chk(`UMD_OFF_CSA, 32'h21);
        // Two stop bits: completion waits for the second one, 16 cycles later.
        apb(1'b1, `UMD_OFF_CTRL, 32'hf7);
        apb(1'b1, `UMD_OFF_DATA, 32'h55);
        repeat (180) @(posedge pclk);
        rd_chk(`UMD_OFF_CSA, 32'h21);
        repeat (20) @(posedge pclk);
        rd_chk(`UMD_OFF_CSA, 32'h61);
        // Slower sample tick and a sender about three percent fast still decode.
        apb(1'b1, `UMD_OFF_BAUD, 32'h1);
        rd_chk(`UMD_OFF_BAUD, 32'h1);
        spb = 5'h1f;
        u_node.send_frame(9'h1e7, 1'b1);
        rd_chk(`UMD_OFF_DATA, 32'he7);
        complete_run();
    end
endmodule
`default_nettype wire

// ===== verification/umd_node.sv
`timescale 1ns/10ps
`default_nettype none
module umd_node (
    input  wire logic       pclk,     // System clock, used as bit timer.
    input  wire logic       line_in,  // Line driven by the block.
    output logic            line_out, // Line into the block.
    input  wire logic [4:0] spb,      // Clock cycles per bit.
    input  wire logic [3:0] nbits     // Data bits per frame.
);
    logic [8:0] rx_q[$];
    logic [8:0] sh;
    int         i;

    // The line idles high between frames.
    initial line_out = 1'b1;

    // Sender runs at spb cycles per bit; only the last test sets it off the block's rate, about three percent fast.
    // For nine-bit frames data[8] is the frame type bit.
    task automatic send_frame(input logic [8:0] data, input logic stop);
        line_out <= 1'b0;
        repeat (spb) @(posedge pclk);
        for (int b = 0; b < nbits; b++)
        begin
            line_out <= data[b];
            repeat (spb) @(posedge pclk);
        end
        // First stop carries the frame type for short characters, second is always high.
        line_out <= stop;
        repeat (spb) @(posedge pclk);
        line_out <= 1'b1;
        repeat (spb) @(posedge pclk);
    endtask

    // Receiver samples mid-bit, so the block's edge updates never race the sample.
    always
    begin
        @(negedge line_in);
        repeat (spb / 2) @(posedge pclk);
        sh = '0;
        for (i = 0; i < nbits; i++)
        begin
            repeat (spb) @(posedge pclk);
            sh[i] = line_in;
        end
        repeat (spb) @(posedge pclk);
        rx_q.push_back(sh);
    end
endmodule
`default_nettype wire
